/* include/cimc_defs.vh */
// Offsets, field positions, reset values and timing counts for the CAN interrupt and mode control block
`ifndef CIMC_DEFS_VH
`define CIMC_DEFS_VH
`define CIMC_OFS_CONTROL 8'h00
`define CIMC_OFS_STATUS 8'h04
`define CIMC_OFS_INTEN 8'h08
`define CIMC_OFS_SOURCES 8'h0c
`define CIMC_CONTROL_RESET 32'h00010002
`define CIMC_STATUS_RESET 32'h00000c02
`define CIMC_CTL_DFZ 16
`define CIMC_CTL_SOFT_RESET 15
`define CIMC_CTL_TTC 7
`define CIMC_CTL_AUTO_BUSOFF_RECOVERY 6
`define CIMC_CTL_AWU 5
`define CIMC_CTL_ARD 4
`define CIMC_CTL_RX_OVERWRITE_OFF 3
`define CIMC_CTL_TFO 2
`define CIMC_CTL_SLP 1
`define CIMC_CTL_INIT 0
`define CIMC_ST_RXL 11
`define CIMC_ST_RX_LAST_SAMPLE 10
`define CIMC_ST_SLEEP_ENTERED_FLAG 4
`define CIMC_ST_WAKE_FLAG 3
`define CIMC_ST_ERROR_SUMMARY_FLAG 2
`define CIMC_ST_SLEEP_STATE_FLAG 1
`define CIMC_ST_IWS 0
`define CIMC_IE_TX 0
`define CIMC_IE_Q0NE 1
`define CIMC_IE_Q0F 2
`define CIMC_IE_Q0O 3
`define CIMC_IE_Q1NE 4
`define CIMC_IE_Q1F 5
`define CIMC_IE_Q1O 6
`define CIMC_IE_WARN 8
`define CIMC_IE_PASS 9
`define CIMC_IE_BOFF 10
`define CIMC_IE_LEC 11
`define CIMC_IE_ERR 15
`define CIMC_IE_WAKE 16
`define CIMC_IE_SLEEP 17
`define CIMC_RECESSIVE_RUN 11
`define CIMC_BUSOFF_RUNS 128
`define CIMC_BIT_CYCLES 16'd250
`endif

/* logic/cimc_recessive_counter.v */
// Counts runs of consecutive recessive bits on the filtered receive line
`timescale 1ns/1ns
module cimc_recessive_counter (
    clk,
    rst_n,
    clear,
    rx_level,
    bit_cycles,
    run_seen,
    runs_ff
);
    input wire clk;
    input wire rst_n;
    input wire clear;
    input wire rx_level;
    input wire [15:0] bit_cycles;
    output reg run_seen;
    output reg [7:0] runs_ff;

    reg [15:0] tick_ff;
    reg [3:0] bits_ff;
    wire bit_end;
    assign bit_end = (tick_ff == bit_cycles - 16'd1);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 16'h0000;
            bits_ff <= 4'h0;
            runs_ff <= 8'h00;
            run_seen <= 1'b0;
        end else if (clear || !rx_level) begin
            // A dominant level restarts the bit grid and the run
            tick_ff <= 16'h0000;
            bits_ff <= 4'h0;
            run_seen <= 1'b0;
            if (clear) begin
                runs_ff <= 8'h00;
            end
        end else begin
            run_seen <= 1'b0;
            tick_ff <= bit_end ? 16'h0000 : tick_ff + 16'd1;
            if (bit_end) begin
                if (bits_ff == 4'd10) begin
                    bits_ff <= 4'h0;
                    run_seen <= 1'b1;
                    if (runs_ff != 8'hff) begin
                        runs_ff <= runs_ff + 8'h01;
                    end
                end else begin
                    bits_ff <= bits_ff + 4'h1;
                end
            end
        end
    end
endmodule

/* logic/cimc_top.v */
// CAN interrupt gathering, control register, status register and mode sequencing
// Operation
// - Queue 1 interrupt on nonzero fill level with its not-empty enable.
// - Queue 1 interrupt on full flag with its full enable.
// - Queue 1 interrupt on overrun flag with its overrun enable.
// - Queue 0 interrupt from the same three conditions and own enables.
// - Transmit interrupt when any mailbox done flag with transmit enable.
// - Error interrupt when summary error flag and its enable are set.
// - Summary error set by enabled warning, passive, bus-off or code 1..6.
// - Error interrupt also on wake flag with wake enable.
// - Error interrupt also on sleep-entered flag with sleep enable.
// - Debug freeze halts traffic only while external debug hold is set.
// - Soft reset bit resets controller into sleep and self-clears.
// - Control bit 7 enables time-triggered communication.
// - Bit 6 lets hardware leave bus-off itself, else software does.
// - Auto wake leaves sleep on bus activity and clears sleep request.
// - Failed frames retransmit unless bit 4 is set.
// - Bit 3 chooses overwrite or discard when receive queue full.
// - Bit 2 picks identifier order or first-in first-out order.
// - Sleep requested in normal mode is entered only after current frame completes.
// - Control bit 0 holds initialisation mode.
// - Status bits 11 and 10 show live and last sampled receive level.
// - Bus-off recovery needs 127 runs of 11 recessive bits.
// - Leaving sleep without an init request completes after 11 consecutive recessive bits.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "cimc_defs.vh"
module cimc_top (
    clk,
    rst_n,
    addr,
    wdata,
    wr_en,
    rd_en,
    rdata_ff,
    rx_pin,
    sample_point,
    frame_busy,
    rxq0_fill_level,
    rxq0_full_flag,
    rxq0_overrun_flag,
    rxq1_fill_level,
    rxq1_full_flag,
    rxq1_overrun_flag,
    mailbox0_done,
    mailbox1_done,
    mailbox2_done,
    warning_error,
    passive_error,
    bus_off_error,
    last_error_code,
    debug_hold_ctrl,
    irq_tx_ff,
    irq_rxq0_ff,
    irq_rxq1_ff,
    irq_err_ff,
    freeze_ff,
    core_reset_ff,
    time_triggered_comm_ff,
    retransmit_off_ff,
    rx_overwrite_off_ff,
    tx_queue_order_ff,
    busoff_exit_ff,
    sleep_state_ff,
    init_state_ff
);
    input wire clk;
    input wire rst_n;
    input wire [7:0] addr;
    input wire [31:0] wdata;
    input wire wr_en;
    input wire rd_en;
    output reg [31:0] rdata_ff;
    input wire rx_pin;
    input wire sample_point;
    input wire frame_busy;
    input wire [1:0] rxq0_fill_level;
    input wire rxq0_full_flag;
    input wire rxq0_overrun_flag;
    input wire [1:0] rxq1_fill_level;
    input wire rxq1_full_flag;
    input wire rxq1_overrun_flag;
    input wire mailbox0_done;
    input wire mailbox1_done;
    input wire mailbox2_done;
    input wire warning_error;
    input wire passive_error;
    input wire bus_off_error;
    input wire [2:0] last_error_code;
    input wire debug_hold_ctrl;
    output reg irq_tx_ff;
    output reg irq_rxq0_ff;
    output reg irq_rxq1_ff;
    output reg irq_err_ff;
    output reg freeze_ff;
    output reg core_reset_ff;
    output reg time_triggered_comm_ff;
    output reg retransmit_off_ff;
    output reg rx_overwrite_off_ff;
    output reg tx_queue_order_ff;
    output reg busoff_exit_ff;
    output reg sleep_state_ff;
    output reg init_state_ff;

    localparam [3:0] ST_SLEEP = 4'b0001;
    localparam [3:0] ST_INIT = 4'b0010;
    localparam [3:0] ST_NORMAL = 4'b0100;
    localparam [3:0] ST_WAKE = 4'b1000;
    localparam [31:0] CTL_RESET = `CIMC_CONTROL_RESET;

    reg [16:0] ctl_ff;
    reg [17:0] inten_ff;
    reg err_flag_ff;
    reg wake_flag_ff;
    reg sleep_flag_ff;
    reg [2:0] rx_sync_ff;
    reg rx_level_ff;
    reg rx_last_ff;
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg rx_prev_ff;
    reg busoff_seen_ff;
    reg busoff_armed_ff;
    reg [31:0] nxt_rdata;

    wire wr_ctl = wr_en && (addr == `CIMC_OFS_CONTROL);
    wire wr_stat = wr_en && (addr == `CIMC_OFS_STATUS);
    wire wr_ie = wr_en && (addr == `CIMC_OFS_INTEN);
    wire lec_valid = (last_error_code != 3'd0) && (last_error_code != 3'd7);
    wire err_event = (warning_error && inten_ff[`CIMC_IE_WARN]) ||
                     (passive_error && inten_ff[`CIMC_IE_PASS]) ||
                     (bus_off_error && inten_ff[`CIMC_IE_BOFF]) ||
                     (lec_valid && inten_ff[`CIMC_IE_LEC]);
    // Falling edge on the filtered line is bus activity while asleep
    wire bus_activity = rx_prev_ff && !rx_level_ff;
    wire wake_event = (state_ff == ST_SLEEP) && bus_activity;
    wire sleep_enter = (nxt_state == ST_SLEEP) && (state_ff != ST_SLEEP);
    wire rec_clear = (state_ff != ST_WAKE) && !(bus_off_error && busoff_armed_ff);
    wire run_seen;
    wire [7:0] run_count;

    cimc_recessive_counter u_runs (
        .clk(clk),
        .rst_n(rst_n),
        .clear(rec_clear),
        .rx_level(rx_level_ff),
        .bit_cycles(`CIMC_BIT_CYCLES),
        .run_seen(run_seen),
        .runs_ff(run_count)
    );

    // Three stage filter: level changes once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_ff <= 3'b111;
            rx_level_ff <= 1'b1;
            rx_last_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], rx_pin};
            if (rx_sync_ff[1] == rx_sync_ff[2]) begin
                rx_level_ff <= rx_sync_ff[2];
            end
            if (sample_point) begin
                rx_last_ff <= rx_level_ff;
            end
            rx_prev_ff <= rx_level_ff;
        end
    end

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SLEEP: begin
                if (ctl_ff[`CIMC_CTL_INIT]) begin
                    nxt_state = ST_INIT;
                end else if (!ctl_ff[`CIMC_CTL_SLP]) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_INIT: begin
                if (!ctl_ff[`CIMC_CTL_INIT]) begin
                    // Wake sequencing applies only when leaving sleep
                    nxt_state = ctl_ff[`CIMC_CTL_SLP] ? ST_SLEEP : ST_NORMAL;
                end
            end
            ST_WAKE: begin
                if (ctl_ff[`CIMC_CTL_INIT]) begin
                    nxt_state = ST_INIT;
                end else if (ctl_ff[`CIMC_CTL_SLP]) begin
                    nxt_state = ST_SLEEP;
                end else if (run_seen) begin
                    nxt_state = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (ctl_ff[`CIMC_CTL_INIT]) begin
                    nxt_state = ST_INIT;
                end else if (ctl_ff[`CIMC_CTL_SLP] && !frame_busy) begin
                    nxt_state = ST_SLEEP;
                end
            end
            default: begin
                nxt_state = ST_SLEEP;
            end
        endcase
        if (ctl_ff[`CIMC_CTL_SOFT_RESET]) begin
            nxt_state = ST_SLEEP;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_SLEEP;
            ctl_ff <= CTL_RESET[16:0];
            inten_ff <= 18'h00000;
            err_flag_ff <= 1'b0;
            wake_flag_ff <= 1'b0;
            sleep_flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (ctl_ff[`CIMC_CTL_SOFT_RESET]) begin
                // Soft reset returns control and enables to reset values
                ctl_ff <= CTL_RESET[16:0];
                inten_ff <= 18'h00000;
            end else begin
                if (wr_ctl) begin
                    ctl_ff <= {wdata[16:15], 7'h00, wdata[7:0]};
                end
                if (wr_ie) begin
                    inten_ff <= {wdata[17:15], 3'h0, wdata[11:8], 1'b0, wdata[6:0]};
                end
                if (wake_event && ctl_ff[`CIMC_CTL_AWU]) begin
                    ctl_ff[`CIMC_CTL_SLP] <= 1'b0;
                end
            end
            // Hardware set wins over a write-one clear in the same cycle
            if (err_event) begin
                err_flag_ff <= 1'b1;
            end else if (wr_stat && wdata[`CIMC_ST_ERROR_SUMMARY_FLAG]) begin
                err_flag_ff <= 1'b0;
            end
            if (wake_event) begin
                wake_flag_ff <= 1'b1;
            end else if (wr_stat && wdata[`CIMC_ST_WAKE_FLAG]) begin
                wake_flag_ff <= 1'b0;
            end
            if (sleep_enter) begin
                sleep_flag_ff <= 1'b1;
            end else if ((wr_stat && wdata[`CIMC_ST_SLEEP_ENTERED_FLAG]) || (state_ff != ST_SLEEP)) begin
                sleep_flag_ff <= 1'b0;
            end
        end
    end

    // Bus-off exit: auto mode arms at once, manual mode only once in init mode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busoff_seen_ff <= 1'b0;
            busoff_armed_ff <= 1'b0;
            busoff_exit_ff <= 1'b0;
        end else begin
            busoff_exit_ff <= 1'b0;
            if (!bus_off_error) begin
                busoff_seen_ff <= 1'b0;
                busoff_armed_ff <= 1'b0;
            end else begin
                busoff_seen_ff <= 1'b1;
                if (ctl_ff[`CIMC_CTL_AUTO_BUSOFF_RECOVERY]) begin
                    busoff_armed_ff <= 1'b1;
                end else if (busoff_seen_ff && state_ff == ST_INIT) begin
                    busoff_armed_ff <= 1'b1;
                end
                if (busoff_armed_ff && run_seen && run_count == (`CIMC_BUSOFF_RUNS - 1)) begin
                    busoff_exit_ff <= 1'b1;
                    busoff_armed_ff <= 1'b0;
                end
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_tx_ff <= 1'b0;
            irq_rxq0_ff <= 1'b0;
            irq_rxq1_ff <= 1'b0;
            irq_err_ff <= 1'b0;
            freeze_ff <= 1'b0;
            core_reset_ff <= 1'b0;
            time_triggered_comm_ff <= 1'b0;
            retransmit_off_ff <= 1'b0;
            rx_overwrite_off_ff <= 1'b0;
            tx_queue_order_ff <= 1'b0;
            sleep_state_ff <= 1'b1;
            init_state_ff <= 1'b0;
        end else begin
            irq_tx_ff <= (mailbox0_done || mailbox1_done || mailbox2_done) && inten_ff[`CIMC_IE_TX];
            irq_rxq0_ff <= ((rxq0_fill_level != 2'b00) && inten_ff[`CIMC_IE_Q0NE]) ||
                           (rxq0_full_flag && inten_ff[`CIMC_IE_Q0F]) ||
                           (rxq0_overrun_flag && inten_ff[`CIMC_IE_Q0O]);
            irq_rxq1_ff <= ((rxq1_fill_level != 2'b00) && inten_ff[`CIMC_IE_Q1NE]) ||
                           (rxq1_full_flag && inten_ff[`CIMC_IE_Q1F]) ||
                           (rxq1_overrun_flag && inten_ff[`CIMC_IE_Q1O]);
            irq_err_ff <= (err_flag_ff && inten_ff[`CIMC_IE_ERR]) ||
                          (wake_flag_ff && inten_ff[`CIMC_IE_WAKE]) ||
                          (sleep_flag_ff && inten_ff[`CIMC_IE_SLEEP]);
            freeze_ff <= ctl_ff[`CIMC_CTL_DFZ] && debug_hold_ctrl;
            core_reset_ff <= ctl_ff[`CIMC_CTL_SOFT_RESET];
            time_triggered_comm_ff <= ctl_ff[`CIMC_CTL_TTC];
            retransmit_off_ff <= ctl_ff[`CIMC_CTL_ARD];
            rx_overwrite_off_ff <= ctl_ff[`CIMC_CTL_RX_OVERWRITE_OFF];
            tx_queue_order_ff <= ctl_ff[`CIMC_CTL_TFO];
            // Sleep state holds until the recessive run ends the wake phase
            sleep_state_ff <= (nxt_state == ST_SLEEP) || (nxt_state == ST_WAKE);
            init_state_ff <= (nxt_state == ST_INIT);
        end
    end

    always @* begin
        nxt_rdata = 32'h00000000;
        case (addr)
            `CIMC_OFS_CONTROL: nxt_rdata = {15'h0000, ctl_ff};
            `CIMC_OFS_STATUS: begin
                nxt_rdata[`CIMC_ST_RXL] = rx_level_ff;
                nxt_rdata[`CIMC_ST_RX_LAST_SAMPLE] = rx_last_ff;
                nxt_rdata[`CIMC_ST_SLEEP_ENTERED_FLAG] = sleep_flag_ff;
                nxt_rdata[`CIMC_ST_WAKE_FLAG] = wake_flag_ff;
                nxt_rdata[`CIMC_ST_ERROR_SUMMARY_FLAG] = err_flag_ff;
                nxt_rdata[`CIMC_ST_SLEEP_STATE_FLAG] = (state_ff == ST_SLEEP) || (state_ff == ST_WAKE);
                nxt_rdata[`CIMC_ST_IWS] = (state_ff == ST_INIT);
            end
            `CIMC_OFS_INTEN: nxt_rdata = {14'h0000, inten_ff};
            `CIMC_OFS_SOURCES: nxt_rdata = {16'h0000, 8'h00, run_count};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= rd_en ? nxt_rdata : 32'h00000000;
        end
    end
endmodule

/* verification/cimc_can_node.sv */
// Bus-side node model driving the receive pin of the block
`timescale 1ns/1ns
module cimc_can_node (
    input wire clk,
    input wire dom_req,
    output logic rx_pin
);
    logic dom_ff = 1'b0;
    // Termination keeps the bus recessive (high) while no node drives dominant
    always_ff @(posedge clk) dom_ff <= dom_req;
    assign rx_pin = ~dom_ff;
endmodule

/* verification/cimc_props.sv */
// Port-level assertions for the CAN interrupt and mode control block
`timescale 1ns/1ns
module cimc_props (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rx_pin,
    input wire frame_busy,
    input wire [1:0] rxq0_fill_level,
    input wire rxq0_full_flag,
    input wire rxq0_overrun_flag,
    input wire [1:0] rxq1_fill_level,
    input wire rxq1_full_flag,
    input wire rxq1_overrun_flag,
    input wire mailbox0_done,
    input wire mailbox1_done,
    input wire mailbox2_done,
    input wire warning_error,
    input wire [2:0] last_error_code,
    input wire debug_hold_ctrl,
    input wire irq_tx_ff,
    input wire irq_rxq0_ff,
    input wire irq_rxq1_ff,
    input wire irq_err_ff,
    input wire freeze_ff,
    input wire core_reset_ff,
    input wire time_triggered_comm_ff,
    input wire retransmit_off_ff,
    input wire rx_overwrite_off_ff,
    input wire tx_queue_order_ff,
    input wire sleep_state_ff
);
    logic [17:0] en_ff;
    logic [16:0] ctl_ff;
    logic [1:0] quiet_ff;
    logic [11:0] rec_ff;
    logic q0, q1, tx, lec;
    assign q0 = (rxq0_fill_level != 2'h0 && en_ff[1]) || (rxq0_full_flag && en_ff[2]) || (rxq0_overrun_flag && en_ff[3]);
    assign q1 = (rxq1_fill_level != 2'h0 && en_ff[4]) || (rxq1_full_flag && en_ff[5]) || (rxq1_overrun_flag && en_ff[6]);
    assign tx = (mailbox0_done || mailbox1_done || mailbox2_done) && en_ff[0];
    assign lec = last_error_code != 3'h0 && last_error_code != 3'h7;
    // Shadows resync a few cycles after a soft reset; checks pause meanwhile
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= 18'h0;
            ctl_ff <= 17'h10002;
            quiet_ff <= 2'h3;
            rec_ff <= 12'h0;
        end else begin
            quiet_ff <= core_reset_ff ? 2'h0 : (quiet_ff == 2'h3 ? quiet_ff : quiet_ff + 2'h1);
            en_ff <= (quiet_ff == 2'h0) ? 18'h0 : ((wr_en && addr == 8'h08) ? wdata[17:0] : en_ff);
            ctl_ff <= (quiet_ff == 2'h0) ? 17'h10002 : ((wr_en && addr == 8'h00) ? wdata[16:0] : ctl_ff);
            rec_ff <= !rx_pin ? 12'h0 : (rec_ff == 12'hfff ? rec_ff : rec_ff + 12'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_q0_level: assert property (quiet_ff == 2'h3 |-> irq_rxq0_ff == $past(q0))
        else $error("queue 0 interrupt wrong");
    a_q1_level: assert property (quiet_ff == 2'h3 |-> irq_rxq1_ff == $past(q1))
        else $error("queue 1 interrupt wrong");
    a_tx_level: assert property (quiet_ff == 2'h3 |-> irq_tx_ff == $past(tx))
        else $error("transmit interrupt wrong");
    a_err_warn: assert property (quiet_ff == 2'h3 && warning_error && en_ff[8] && en_ff[15] |-> ##[1:3] irq_err_ff)
        else $error("warning did not raise error interrupt");
    a_err_code: assert property (quiet_ff == 2'h3 && lec && en_ff[11] && en_ff[15] |-> ##[1:3] irq_err_ff)
        else $error("error code did not raise error interrupt");
    a_freeze_gate: assert property (quiet_ff == 2'h3 |-> freeze_ff == $past(ctl_ff[16] && debug_hold_ctrl))
        else $error("freeze output wrong");
    a_mode_copies: assert property (quiet_ff == 2'h3 |->
        {time_triggered_comm_ff, retransmit_off_ff, rx_overwrite_off_ff, tx_queue_order_ff}
        == $past({ctl_ff[7], ctl_ff[4], ctl_ff[3], ctl_ff[2]}))
        else $error("control copy wrong");
    a_reset_pulse: assert property ($rose(core_reset_ff) |=> !core_reset_ff)
        else $error("soft reset pulse too long");
    a_reset_cause: assert property (wr_en && addr == 8'h00 && wdata[15] |-> ##[1:3] core_reset_ff)
        else $error("soft reset not issued");
    a_sleep_waits: assert property (quiet_ff == 2'h3 && frame_busy && $past(frame_busy) && $past(frame_busy, 2)
        |-> !$rose(sleep_state_ff))
        else $error("sleep entered during a frame");
    a_wake_run: assert property ($fell(sleep_state_ff) |-> rec_ff >= 12'd2500)
        else $error("sleep left without recessive run");
endmodule
bind cimc_top cimc_props i_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rx_pin(rx_pin), .frame_busy(frame_busy), .rxq0_fill_level(rxq0_fill_level),
    .rxq0_full_flag(rxq0_full_flag), .rxq0_overrun_flag(rxq0_overrun_flag), .rxq1_fill_level(rxq1_fill_level),
    .rxq1_full_flag(rxq1_full_flag), .rxq1_overrun_flag(rxq1_overrun_flag), .mailbox0_done(mailbox0_done),
    .mailbox1_done(mailbox1_done), .mailbox2_done(mailbox2_done), .warning_error(warning_error),
    .last_error_code(last_error_code), .debug_hold_ctrl(debug_hold_ctrl), .irq_tx_ff(irq_tx_ff),
    .irq_rxq0_ff(irq_rxq0_ff), .irq_rxq1_ff(irq_rxq1_ff), .irq_err_ff(irq_err_ff), .freeze_ff(freeze_ff),
    .core_reset_ff(core_reset_ff), .time_triggered_comm_ff(time_triggered_comm_ff),
    .retransmit_off_ff(retransmit_off_ff), .rx_overwrite_off_ff(rx_overwrite_off_ff),
    .tx_queue_order_ff(tx_queue_order_ff), .sleep_state_ff(sleep_state_ff));

/* verification/tb_cimc_top.sv */
// Self-checking bench for the CAN interrupt and mode control block
`timescale 1ns/1ns
`define CIMC_CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin error_cnt++; $display("FAIL t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module tb_cimc_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sample_point = 1'b0;
    logic frame_busy = 1'b0;
    logic debug_hold_ctrl = 1'b0;
    logic dom_req = 1'b0;
    logic [16:0] src = 17'h0;
    logic [31:0] rdata_ff, d;
    logic rx_pin, irq_tx_ff, irq_rxq0_ff, irq_rxq1_ff, irq_err_ff, freeze_ff, core_reset_ff, init_state_ff;
    logic busoff_exit_ff;
    logic time_triggered_comm_ff, retransmit_off_ff, rx_overwrite_off_ff, tx_queue_order_ff, sleep_state_ff;
    logic e;
    int error_cnt = 0;
    int total_checks = 0;
    int eb[11] = '{1, 1, 2, 3, 4, 4, 5, 6, 0, 0, 0};
    logic [31:0] pat[4] = '{32'hfffe7f9d, 32'h00000011, 32'h00000088, 32'h00000084};
    always #2 clk = ~clk;
    cimc_can_node i_node (.clk(clk), .dom_req(dom_req), .rx_pin(rx_pin));
    cimc_top i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata_ff(rdata_ff), .rx_pin(rx_pin), .sample_point(sample_point), .frame_busy(frame_busy),
        .rxq0_fill_level(src[1:0]), .rxq0_full_flag(src[2]), .rxq0_overrun_flag(src[3]),
        .rxq1_fill_level(src[5:4]), .rxq1_full_flag(src[6]), .rxq1_overrun_flag(src[7]),
        .mailbox0_done(src[8]), .mailbox1_done(src[9]), .mailbox2_done(src[10]), .warning_error(src[11]),
        .passive_error(src[12]), .bus_off_error(src[13]), .last_error_code(src[16:14]),
        .debug_hold_ctrl(debug_hold_ctrl), .irq_tx_ff(irq_tx_ff), .irq_rxq0_ff(irq_rxq0_ff),
        .irq_rxq1_ff(irq_rxq1_ff), .irq_err_ff(irq_err_ff), .freeze_ff(freeze_ff), .core_reset_ff(core_reset_ff),
        .time_triggered_comm_ff(time_triggered_comm_ff), .retransmit_off_ff(retransmit_off_ff),
        .rx_overwrite_off_ff(rx_overwrite_off_ff), .tx_queue_order_ff(tx_queue_order_ff),
        .busoff_exit_ff(busoff_exit_ff),
        .sleep_state_ff(sleep_state_ff), .init_state_ff(init_state_ff));
    task finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata_ff;
    endtask
    task wait_sleep(input logic v, input int n);
        int i;
        for (i = 0; i < n && sleep_state_ff !== v; i++) @(posedge clk);
        if (sleep_state_ff !== v) begin
            error_cnt++;
            finish_test();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00);
        `CIMC_CHK(d, 32'h00010002)
        rd(8'h04);
        `CIMC_CHK(d, 32'h00000c02)
        rd(8'h10);
        `CIMC_CHK(d, 32'h0)
        wr(8'h00, 32'h84);
        repeat (2000) @(posedge clk);
        `CIMC_CHK(sleep_state_ff, 1'b1)
        wait_sleep(1'b0, 1500);
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, pat[k]);
            repeat (3) @(posedge clk);
            `CIMC_CHK({time_triggered_comm_ff, retransmit_off_ff, rx_overwrite_off_ff, tx_queue_order_ff}, {pat[k][7], pat[k][4], pat[k][3], pat[k][2]})
            `CIMC_CHK(init_state_ff, pat[k][0])
            rd(8'h00);
            `CIMC_CHK(d, pat[k] & 32'h000100ff)
            rd(8'h04);
            `CIMC_CHK(d[0], pat[k][0])
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, {15'h0, k[1], 16'h0084});
            @(posedge clk) debug_hold_ctrl <= k[0];
            repeat (2) @(posedge clk);
            `CIMC_CHK(freeze_ff, k[1] & k[0])
        end
        for (int k = 0; k < 22; k++) begin
            wr(8'h08, (k % 2) ? 32'h7f : 32'h7f & ~(32'h1 << eb[k / 2]));
            @(posedge clk) src <= 17'h1 << (k / 2);
            repeat (2) @(posedge clk);
            `CIMC_CHK({irq_tx_ff, irq_rxq1_ff, irq_rxq0_ff}, (k % 2) ? 3'h1 << (k / 8) : 3'h0)
            @(posedge clk) src <= 17'h0;
        end
        for (int j = 0; j < 11; j++) begin
            e = j < 3 || (j > 3 && j < 10);
            wr(8'h08, 32'h8000 | (32'h1 << (j < 3 ? 8 + j : 11)));
            @(posedge clk) src <= (j < 3) ? 17'h800 << j : 17'((j - 3) << 14);
            repeat (4) @(posedge clk);
            `CIMC_CHK(irq_err_ff, e)
            `CIMC_CHK(busoff_exit_ff, 1'b0)
            rd(8'h04);
            `CIMC_CHK(d[2], e)
            @(posedge clk) src <= 17'h0;
            wr(8'h04, 32'h4);
            rd(8'h04);
            `CIMC_CHK(d[2], 1'b0)
        end
        wr(8'h08, 32'h100);
        @(posedge clk) src <= 17'h800;
        repeat (4) @(posedge clk);
        rd(8'h04);
        `CIMC_CHK({irq_err_ff, d[2]}, 2'b01)
        @(posedge clk) src <= 17'h0;
        wr(8'h04, 32'h4);
        wr(8'h08, 32'h20000);
        @(posedge clk) frame_busy <= 1'b1;
        wr(8'h00, 32'h2);
        repeat (40) @(posedge clk);
        `CIMC_CHK(sleep_state_ff, 1'b0)
        frame_busy <= 1'b0;
        wait_sleep(1'b1, 20);
        repeat (2) @(posedge clk);
        rd(8'h04);
        `CIMC_CHK(d[4:0] & 5'h12, 5'h12)
        `CIMC_CHK(irq_err_ff, 1'b1)
        wr(8'h04, 32'h10);
        repeat (2) @(posedge clk);
        `CIMC_CHK(irq_err_ff, 1'b0)
        wr(8'h08, 32'h10000);
        wr(8'h00, 32'h22);
        @(posedge clk) dom_req <= 1'b1;
        repeat (6) @(posedge clk);
        sample_point <= 1'b1;
        @(posedge clk) sample_point <= 1'b0;
        rd(8'h04);
        `CIMC_CHK(d[11:10], 2'b00)
        @(posedge clk) dom_req <= 1'b0;
        repeat (6) @(posedge clk);
        sample_point <= 1'b1;
        @(posedge clk) sample_point <= 1'b0;
        rd(8'h04);
        `CIMC_CHK({d[11:10], d[3]}, 3'b111)
        `CIMC_CHK(irq_err_ff, 1'b1)
        rd(8'h00);
        `CIMC_CHK(d[1], 1'b0)
        wait_sleep(1'b0, 4000);
        wr(8'h00, 32'h8084);
        repeat (4) @(posedge clk);
        `CIMC_CHK(sleep_state_ff, 1'b1)
        rd(8'h00);
        `CIMC_CHK(d, 32'h00010002)
        rd(8'h08);
        `CIMC_CHK(d, 32'h0)
        finish_test();
    end
endmodule
